// ===== bench/chrc_far_model.sv
// Far side model: pulled-up reset pin and host platform reset
`timescale 1ns/1ps
module chrc_far_model
  import chrc_pkg::*;
(
  // Clock and core reset
  input wire logic clk,
  input wire logic arst_n,
  // Open-drain reset pin
  input wire logic porPinOut,
  input wire logic porPinOe_n,
  input wire logic extPull,
  output logic porPinIn,
  // Host platform reset
  input wire logic coreDomainRst,
  input wire logic hostRstReq,
  output logic lresetIn_n
);
  logic [7:0] holdCnt_ff;
  // Pull-up wins unless the device or the board pulls low
  assign porPinIn = !((!porPinOe_n && !porPinOut) || extPull);
  // Host reset spans core reset plus the extra hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_ff <= 8'(HOST_EXTRA_HOLD_CYC);
    end else if (coreDomainRst) begin
      holdCnt_ff <= 8'(HOST_EXTRA_HOLD_CYC);
    end else if (holdCnt_ff != 8'h00) begin
      holdCnt_ff <= holdCnt_ff - 8'h01;
    end
  end
  assign lresetIn_n = !(coreDomainRst || holdCnt_ff != 8'h00 || hostRstReq);
endmodule // chrc_far_model

// ===== bench/tb_top.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module tb_top
  import chrc_pkg::*;
;
  localparam int POR = 20;
  localparam int IRC = 8;
  localparam logic [15:0] PWR = 16'hFFDF;
  // Bit 15 is the oscillator, on for good once power-up enabled it
  localparam logic [15:0] PIN = 16'h9FDF;
  localparam logic [15:0] COLD = 16'h80DF;
  localparam logic [15:0] WARM = 16'h801C;
  localparam logic [15:0] HOST = 16'h8003;
  logic clk, arst_n, hostPwrRst_n, porPinIn, porPinOut, porPinOe_n;
  logic watchdogEvent, debugSystemResetCmd, lresetIn_n, lpcPowerDown_n;
  logic debugResetKindSel, watchdogResetKindSel, watchdogColdDrivesPin;
  logic hostResetAtPowerupEn, stallFlagClr, statusClr, lpcAccessReq;
  logic lpcLongWait, extPorStatus, watchdogResetStatus, debugResetStatus;
  logic hostStallFlag, coreDomainRst, hostKeyboardResetOut, lfOscEnable;
  logic hostCtlDefaults, strapFloat, strapCapture, clockGenDefault;
  logic tapReset, vccHostDefaults, coreRegDefaults, coreReset;
  logic debugStatusReset, pmcToActive, hostDomainRst, vddHostDefaults;
  logic extPull, hostRstReq;
  logic [3:0] hostResetReloadEn, gpioReload, gpioSeen;
  logic [15:0] obs, seen;
  int bad_count, cmp_count, lowCnt;

  assign obs = {lfOscEnable, hostCtlDefaults, !porPinOe_n, strapFloat,
    strapCapture, clockGenDefault, tapReset, vccHostDefaults, coreDomainRst,
    coreRegDefaults, hostKeyboardResetOut, coreReset, debugStatusReset,
    pmcToActive, hostDomainRst, vddHostDefaults};

  chrc_reset_ctrl #(.PORT_N(4), .POR_CYC(POR), .INTRST_CYC(IRC)) i_dut (
    .clk, .arst_n, .hostPwrRst_n, .porPinIn, .porPinOut, .porPinOe_n,
    .watchdogEvent, .debugSystemResetCmd, .lresetIn_n, .lpcPowerDown_n,
    .debugResetKindSel, .watchdogResetKindSel, .watchdogColdDrivesPin,
    .hostResetAtPowerupEn, .hostResetReloadEn, .stallFlagClr, .statusClr,
    .lpcAccessReq, .lpcLongWait, .extPorStatus, .watchdogResetStatus,
    .debugResetStatus, .hostStallFlag, .coreDomainRst, .hostKeyboardResetOut,
    .lfOscEnable, .hostCtlDefaults, .strapFloat, .strapCapture,
    .clockGenDefault, .tapReset, .vccHostDefaults, .coreRegDefaults,
    .coreReset, .debugStatusReset, .pmcToActive, .hostDomainRst,
    .vddHostDefaults, .gpioReload);

  chrc_far_model i_far (.clk, .arst_n, .porPinOut, .porPinOe_n, .extPull,
    .porPinIn, .coreDomainRst, .hostRstReq, .lresetIn_n);

  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic clr();
    seen = 16'h0000;
    gpioSeen = 4'h0;
    lowCnt = 0;
  endtask

  // Accumulate every action seen; ends on a falling edge
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      seen = seen | obs;
      gpioSeen = gpioSeen | gpioReload;
      lowCnt += int'(!porPinOe_n);
    end
    @(negedge clk);
  endtask

  task automatic sclr();
    statusClr = 1'b1;
    run(1);
    statusClr = 1'b0;
  endtask

  task automatic t_powerup();
    clr();
    run(POR + IRC + 80);
    chk("powerup actions", PWR, seen);
    chk("pin pulse", 16'(POR), 16'(lowCnt));
    chk("stall held", 16'h0001, {15'h0, hostStallFlag});
    lpcAccessReq = 1'b1;
    run(2);
    chk("long wait", 16'h0001, {15'h0, lpcLongWait});
    stallFlagClr = 1'b1;
    run(1);
    stallFlagClr = 1'b0;
    run(3);
    chk("wait done", 16'h0000, {14'h0, hostStallFlag, lpcLongWait});
    lpcAccessReq = 1'b0;
    chk("idle", 16'h8000, obs);
    chk("powerup pin status", 16'h0000, {15'h0, extPorStatus});
    sclr();
  endtask

  task automatic t_pin();
    clr();
    extPull = 1'b1;
    run(4);
    extPull = 1'b0;
    run(120);
    chk("pin actions", PIN, seen);
    chk("pin status", 16'h0004, {13'h0, extPorStatus, watchdogResetStatus,
      debugResetStatus});
    sclr();
  endtask

  task automatic t_wdog(input logic kind, pin, kbd,
                        input logic [15:0] exp);
    watchdogResetKindSel = kind;
    watchdogColdDrivesPin = pin;
    hostResetAtPowerupEn = kbd;
    clr();
    watchdogEvent = 1'b1;
    run(3);
    watchdogEvent = 1'b0;
    run(120);
    // A pulsed pin reads back low and adds a pin reset
    chk("wdog actions", exp, seen);
    chk("wdog pin pulse", pin ? 16'(POR) : 16'h0000, 16'(lowCnt));
    chk("wdog status", pin ? 16'h0006 : 16'h0002, {13'h0, extPorStatus,
      watchdogResetStatus, debugResetStatus});
    sclr();
  endtask

  task automatic t_debug();
    for (int k = 0; k < 2; k++) begin
      debugResetKindSel = k[0];
      clr();
      debugSystemResetCmd = 1'b1;
      run(3);
      debugSystemResetCmd = 1'b0;
      run(120);
      chk("debug actions", k[0] ? WARM : COLD, seen);
      chk("debug status", 16'h0001, {14'h0, watchdogResetStatus,
        debugResetStatus});
      sclr();
    end
  endtask

  task automatic t_host();
    hostResetReloadEn = 4'h5;
    lpcPowerDown_n = 1'b0;
    clr();
    hostRstReq = 1'b1;
    run(4);
    hostRstReq = 1'b0;
    run(10);
    chk("host actions", HOST, seen);
    chk("gpio reload", 16'h0005, {12'h0, gpioSeen});
    clr();
    hostPwrRst_n = 1'b0;
    run(4);
    hostPwrRst_n = 1'b1;
    run(10);
    chk("host power", HOST, seen);
    chk("host power gpio", 16'h0005, {12'h0, gpioSeen});
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {arst_n, watchdogEvent, debugSystemResetCmd, debugResetKindSel} = 4'h0;
    {watchdogResetKindSel, watchdogColdDrivesPin, stallFlagClr} = 3'h0;
    {hostResetAtPowerupEn, statusClr, lpcAccessReq} = 3'h0;
    {extPull, hostRstReq, hostResetReloadEn} = 6'h00;
    hostPwrRst_n = 1'b1;
    lpcPowerDown_n = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_powerup();
    t_pin();
    t_wdog(1'b0, 1'b0, 1'b1, 16'h80FF);
    t_wdog(1'b1, 1'b0, 1'b0, WARM);
    t_wdog(1'b0, 1'b1, 1'b0, 16'hBFDF);
    t_debug();
    t_host();
    conclude();
  end

  // About ten times the expected run length
  initial begin
    #250000;
    bad_count++;
    conclude();
  end
endmodule // tb_top

// ===== rtl/chrc_pkg.sv
// Constants shared by the reset controller files
package chrc_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int POR_PULSE_WIDTH_US = 100;
  localparam int POR_PULSE_CYC = POR_PULSE_WIDTH_US * CLK_MHZ;
  localparam int INT_RESET_CYC = 64;
  localparam int HOST_EXTRA_HOLD_US = 1;
  localparam int HOST_EXTRA_HOLD_CYC = HOST_EXTRA_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // Two-flop pin sampler delay
  localparam int PIN_SYNC_CYC = 2;
  // Reset values
  localparam logic RST_VAL_LOW = 1'h0;
  localparam logic RST_VAL_HIGH = 1'h1;
  // Cascade levels, shallowest first
  typedef enum logic [2:0] {
    CHRC_NONE, CHRC_WARM, CHRC_COLD, CHRC_PIN, CHRC_PWR
  } chrc_level_t;
endpackage

// ===== rtl/chrc_reset_ctrl.sv
// Core and host domain reset source collection and sequencing
`timescale 1ns/1ps
module chrc_reset_ctrl
  import chrc_pkg::*;
#(
  parameter int PORT_N = 4,
  parameter int POR_CYC = POR_PULSE_CYC,
  parameter int INTRST_CYC = INT_RESET_CYC
) (
  // Clock and core supply power-good reset
  input wire logic clk,
  input wire logic arst_n,
  // Host supply power-up reset, active low
  input wire logic hostPwrRst_n,
  // Open-drain power-on-reset pin
  input wire logic porPinIn,
  output logic porPinOut,
  output logic porPinOe_n,
  // Reset requests
  input wire logic watchdogEvent,
  input wire logic debugSystemResetCmd,
  input wire logic lresetIn_n,
  input wire logic lpcPowerDown_n,
  // Configuration bits
  input wire logic debugResetKindSel,
  input wire logic watchdogResetKindSel,
  input wire logic watchdogColdDrivesPin,
  input wire logic hostResetAtPowerupEn,
  input wire logic [PORT_N-1:0] hostResetReloadEn,
  input wire logic stallFlagClr,
  input wire logic statusClr,
  // LPC access
  input wire logic lpcAccessReq,
  output logic lpcLongWait,
  // Status
  output logic extPorStatus,
  output logic watchdogResetStatus,
  output logic debugResetStatus,
  output logic hostStallFlag,
  // Reset actions
  output logic coreDomainRst,
  output logic hostKeyboardResetOut,
  output logic lfOscEnable,
  output logic hostCtlDefaults,
  output logic strapFloat,
  output logic strapCapture,
  output logic clockGenDefault,
  output logic tapReset,
  output logic vccHostDefaults,
  output logic coreRegDefaults,
  output logic coreReset,
  output logic debugStatusReset,
  output logic pmcToActive,
  output logic hostDomainRst,
  output logic vddHostDefaults,
  output logic [PORT_N-1:0] gpioReload
);
  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_DONE} chrc_state_t;

  typedef struct packed {
    chrc_state_t state;
    chrc_level_t level;
    logic [CNT_W-1:0] porCnt;
    logic [CNT_W-1:0] rstCnt;
    logic porDrive;
    logic pwrPulse;
    logic pinSync0;
    logic pinSync1;
    logic lrSync0;
    logic lrSync1;
    logic wdSync0;
    logic wdSync1;
    logic wdPrev;
    logic dbSync0;
    logic dbSync1;
    logic dbPrev;
    logic pwrSeen;
    logic extPorSts;
    logic wdSts;
    logic dbSts;
    logic stall;
    logic longWait;
    logic host_keyboard_reset_out;
    logic osc;
    logic hostDef;
    logic strapFl;
    logic strapCap;
    logic cgDef;
    logic tapRst;
    logic vccDef;
    logic coreDef;
    logic coreRst;
    logic dbgStsRst;
    logic pmcAct;
    logic coreDom;
    logic hostDom;
    logic vddDef;
    logic [PORT_N-1:0] gpioLd;
  } chrc_regs_t;

  localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYC + PIN_SYNC_CYC);
  localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(INTRST_CYC);

  chrc_regs_t st_ff;
  chrc_regs_t nxt_st;
  logic hostSyncRst_n;

  // Deepest of two cascade levels
  function automatic chrc_level_t deeper(chrc_level_t a, chrc_level_t b);
    deeper = (a > b) ? a : b;
  endfunction

  // Host domain reset released on the core clock
  chrc_rst_sync u_host_sync (
    .clk(clk),
    .arst_n(hostPwrRst_n),
    .rawRst(~st_ff.lrSync1),
    .syncRst_n(hostSyncRst_n)
  );

  logic pinEvt, wdEvt, dbEvt;
  chrc_level_t reqLvl;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pinSync0 = porPinIn;
    nxt_st.pinSync1 = st_ff.pinSync0;
    nxt_st.lrSync0 = lresetIn_n;
    nxt_st.lrSync1 = st_ff.lrSync0;
    nxt_st.wdSync0 = watchdogEvent;
    nxt_st.wdSync1 = st_ff.wdSync0;
    nxt_st.wdPrev = st_ff.wdSync1;
    nxt_st.dbSync0 = debugSystemResetCmd;
    nxt_st.dbSync1 = st_ff.dbSync0;
    nxt_st.dbPrev = st_ff.dbSync1;
    nxt_st.pwrSeen = 1'b1;
    // Only the power-up drive and its sampler tail mask the pin
    pinEvt = !st_ff.pinSync1 && st_ff.pwrSeen &&
      !(st_ff.pwrPulse && st_ff.porCnt != '0);
    wdEvt = st_ff.wdSync1 && !st_ff.wdPrev;
    dbEvt = st_ff.dbSync1 && !st_ff.dbPrev;
    reqLvl = CHRC_NONE;
    if (!st_ff.pwrSeen) reqLvl = CHRC_PWR;
    if (pinEvt) reqLvl = deeper(reqLvl, CHRC_PIN);
    if (wdEvt) begin
      reqLvl = deeper(reqLvl,
        watchdogResetKindSel ? CHRC_WARM : CHRC_COLD);
    end
    if (dbEvt) begin
      reqLvl = deeper(reqLvl,
        debugResetKindSel ? CHRC_WARM : CHRC_COLD);
    end
    // Status: a new event wins over a clear
    if (statusClr) begin
      nxt_st.extPorSts = 1'b0;
      nxt_st.wdSts = 1'b0;
      nxt_st.dbSts = 1'b0;
    end
    if (pinEvt) nxt_st.extPorSts = 1'b1;
    if (wdEvt) nxt_st.wdSts = 1'b1;
    if (dbEvt) nxt_st.dbSts = 1'b1;
    // Pin driver; the count outlasts the drive by the sampler delay
    if (st_ff.porCnt != '0) begin
      nxt_st.porCnt = st_ff.porCnt - CNT_W'(1);
    end
    nxt_st.porDrive = (nxt_st.porCnt > CNT_W'(PIN_SYNC_CYC));
    if (wdEvt && !watchdogResetKindSel && watchdogColdDrivesPin) begin
      nxt_st.porCnt = POR_LOAD;
      nxt_st.porDrive = 1'b1;
      nxt_st.pwrPulse = 1'b0;
    end
    if (reqLvl != CHRC_NONE) begin
      nxt_st.state = ST_RESET;
      nxt_st.level = deeper(reqLvl,
        (st_ff.state == ST_RESET) ? st_ff.level : CHRC_NONE);
      nxt_st.rstCnt = RST_LOAD;
      if (reqLvl == CHRC_PWR) begin
        nxt_st.porCnt = POR_LOAD;
        nxt_st.pwrPulse = 1'b1;
        nxt_st.porDrive = 1'b1;
      end
      if (reqLvl >= CHRC_COLD) nxt_st.stall = 1'b1;
    end else begin
      case (st_ff.state)
        ST_IDLE: nxt_st.state = ST_IDLE;
        ST_RESET: begin
          if (st_ff.rstCnt != '0) begin
            nxt_st.rstCnt = st_ff.rstCnt - CNT_W'(1);
          end else begin
            nxt_st.state = ST_DONE;
            nxt_st.level = CHRC_NONE;
          end
        end
        ST_DONE: nxt_st.state = ST_IDLE;
        default: nxt_st.state = ST_IDLE;
      endcase
    end
    // Stall flag ends only once the internal reset is over
    if (stallFlagClr && nxt_st.state != ST_RESET) begin
      nxt_st.stall = 1'b0;
    end
    nxt_st.longWait = lpcAccessReq && nxt_st.stall;
    nxt_st.host_keyboard_reset_out = hostResetAtPowerupEn &&
      nxt_st.state == ST_RESET && nxt_st.level >= CHRC_COLD;
    // Cascade: each level includes all shallower actions
    nxt_st.osc = st_ff.osc || nxt_st.level == CHRC_PWR;
    nxt_st.hostDef = nxt_st.level == CHRC_PWR;
    nxt_st.strapFl = nxt_st.level >= CHRC_PIN;
    nxt_st.strapCap = st_ff.strapFl && !nxt_st.strapFl;
    nxt_st.cgDef = nxt_st.level >= CHRC_PIN;
    nxt_st.tapRst = nxt_st.level >= CHRC_PIN;
    nxt_st.vccDef = nxt_st.level >= CHRC_PIN;
    nxt_st.coreDef = nxt_st.level >= CHRC_COLD;
    nxt_st.coreDom = nxt_st.level >= CHRC_COLD;
    nxt_st.coreRst = nxt_st.level >= CHRC_WARM;
    nxt_st.dbgStsRst = nxt_st.level >= CHRC_WARM;
    nxt_st.pmcAct = nxt_st.level >= CHRC_WARM;
    // Host side, regardless of LPC power-down
    nxt_st.hostDom = !hostSyncRst_n;
    nxt_st.vddDef = !hostSyncRst_n;
    nxt_st.gpioLd = {PORT_N{!hostSyncRst_n}} & hostResetReloadEn;
  end

  // Pin, watchdog and debug inputs pass two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.pinSync0 <= RST_VAL_HIGH;
      st_ff.pinSync1 <= RST_VAL_HIGH;
      st_ff.stall <= RST_VAL_HIGH;
      st_ff.coreDom <= RST_VAL_HIGH;
      st_ff.coreRst <= RST_VAL_HIGH;
      st_ff.hostDom <= RST_VAL_HIGH;
      st_ff.state <= ST_IDLE;
      st_ff.level <= CHRC_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open drain: enable low while pulling low
  assign porPinOut = RST_VAL_LOW;
  assign porPinOe_n = ~st_ff.porDrive;
  assign lpcLongWait = st_ff.longWait;
  assign extPorStatus = st_ff.extPorSts;
  assign watchdogResetStatus = st_ff.wdSts;
  assign debugResetStatus = st_ff.dbSts;
  assign hostStallFlag = st_ff.stall;
  assign coreDomainRst = st_ff.coreDom;
  assign hostKeyboardResetOut = st_ff.host_keyboard_reset_out;
  assign lfOscEnable = st_ff.osc;
  assign hostCtlDefaults = st_ff.hostDef;
  assign strapFloat = st_ff.strapFl;
  assign strapCapture = st_ff.strapCap;
  assign clockGenDefault = st_ff.cgDef;
  assign tapReset = st_ff.tapRst;
  assign vccHostDefaults = st_ff.vccDef;
  assign coreRegDefaults = st_ff.coreDef;
  assign coreReset = st_ff.coreRst;
  assign debugStatusReset = st_ff.dbgStsRst;
  assign pmcToActive = st_ff.pmcAct;
  assign hostDomainRst = st_ff.hostDom;
  assign vddHostDefaults = st_ff.vddDef;
  assign gpioReload = st_ff.gpioLd;

  // Checks
  property p_pin_status;
    @(posedge clk) disable iff (!arst_n)
      (!st_ff.pinSync1 && st_ff.pwrSeen && st_ff.porCnt == '0)
      |=> extPorStatus;
  endproperty
  a_pin_status: assert property (p_pin_status)
    else $error("pin reset did not set status");

  property p_dbg_cold;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.dbSync1 && !st_ff.dbPrev && !debugResetKindSel)
      |=> coreRegDefaults && debugResetStatus;
  endproperty
  a_dbg_cold: assert property (p_dbg_cold)
    else $error("debug cold reset missing");

  property p_dbg_warm;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.dbSync1 && !st_ff.dbPrev && debugResetKindSel &&
       st_ff.state == ST_IDLE && st_ff.wdSync1 == st_ff.wdPrev &&
       st_ff.pinSync1 && st_ff.pwrSeen)
      |=> coreReset && !coreRegDefaults && debugResetStatus;
  endproperty
  a_dbg_warm: assert property (p_dbg_warm)
    else $error("debug warm reset wrong");

  property p_wd_cold;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.wdSync1 && !st_ff.wdPrev && !watchdogResetKindSel)
      |=> coreDomainRst && watchdogResetStatus;
  endproperty
  a_wd_cold: assert property (p_wd_cold)
    else $error("watchdog cold reset missing");

  property p_wd_warm;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.wdSync1 && !st_ff.wdPrev && watchdogResetKindSel)
      |=> coreReset && pmcToActive && watchdogResetStatus;
  endproperty
  a_wd_warm: assert property (p_wd_warm)
    else $error("watchdog warm reset missing");

  property p_warm_no_core_dom;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.level == CHRC_WARM) |-> !coreDomainRst;
  endproperty
  a_warm_no_core_dom: assert property (p_warm_no_core_dom)
    else $error("warm reset raised core domain reset");

  property p_cascade;
    @(posedge clk) disable iff (!arst_n)
      tapReset |-> coreRegDefaults && coreReset && debugStatusReset;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("pin reset cascade incomplete");

  property p_stall_held;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.state == ST_RESET && st_ff.level >= CHRC_COLD)
      |-> hostStallFlag;
  endproperty
  a_stall_held: assert property (p_stall_held)
    else $error("stall flag dropped during reset");

  property p_wd_pin;
    @(posedge clk) disable iff (!arst_n)
      (st_ff.wdSync1 && !st_ff.wdPrev && !watchdogResetKindSel &&
       watchdogColdDrivesPin) |=> !porPinOe_n [*8];
  endproperty
  a_wd_pin: assert property (p_wd_pin)
    else $error("watchdog cold did not pulse pin");

  property p_host_reload;
    @(posedge clk) disable iff (!arst_n)
      $fell(hostSyncRst_n) |=> hostDomainRst && vddHostDefaults &&
      gpioReload == $past(hostResetReloadEn);
  endproperty
  a_host_reload: assert property (p_host_reload)
    else $error("host reset did not load defaults");
endmodule // chrc_reset_ctrl

// ===== rtl/chrc_rst_sync.sv
// Reset synchroniser: async assert, clocked release
`timescale 1ns/1ps
module chrc_rst_sync
  import chrc_pkg::*;
(
  // Clock and raw reset request
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rawRst,
  // Synchronised reset, active low
  output logic syncRst_n
);
  typedef struct packed {
    logic s0;
    logic s1;
  } chrc_sync_t;

  chrc_sync_t st_ff;
  chrc_sync_t nxt_st;
  wire logic combRst_n;

  assign combRst_n = arst_n & ~rawRst;

  always_comb begin
    nxt_st.s0 = RST_VAL_HIGH;
    nxt_st.s1 = st_ff.s0;
  end

  // Assert without clock, release on an edge
  always_ff @(posedge clk or negedge combRst_n) begin
    if (!combRst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign syncRst_n = st_ff.s1;
endmodule // chrc_rst_sync
